// >>> logic/upc_pkg.sv
package upc_pkg;

  // Core clock rate and the fastest link clocks each bus width allows
  localparam int unsigned CORE_CLK_MHZ = 200;
  localparam int unsigned LINK_MAX_MHZ_8BIT = 52;
  localparam int unsigned LINK_MAX_MHZ_16BIT = 33;

  // Shortest legal link period in core cycles, rounded down
  localparam int unsigned MIN_PERIOD_CYC_8BIT = CORE_CLK_MHZ / LINK_MAX_MHZ_8BIT;
  localparam int unsigned MIN_PERIOD_CYC_16BIT = CORE_CLK_MHZ / LINK_MAX_MHZ_16BIT;

  // Widths of the link buses
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 5;

  // Index of the last word of a cell, counting the start word as index 0
  localparam logic [5:0] CELL_LAST_16BIT = 6'h1a;
  localparam logic [5:0] CELL_LAST_8BIT = 6'h34;
  localparam logic [5:0] CELL_IDX_FIRST = 6'h00;
  localparam logic [5:0] CELL_IDX_SECOND = 6'h01;

  // Link period measurement counter
  localparam int unsigned RATE_CNT_W = 4;
  localparam logic [RATE_CNT_W-1:0] RATE_CNT_MAX = 4'hf;

  // Transmit queue entry: start flag, parity error flag, cell word
  localparam int unsigned TXQ_DEPTH = 8;
  localparam int unsigned TXQ_W = WORD_W + 2;
  localparam int unsigned TXQ_FIRST_BIT = WORD_W + 1;
  localparam int unsigned TXQ_PERR_BIT = WORD_W;

  // Upper byte value used in 8-bit mode
  localparam logic [BYTE_W-1:0] UPPER_BYTE_ZERO = 8'h00;

  typedef enum logic {UPC_TX_IDLE, UPC_TX_CELL} upc_tx_state_e;

  // All link inputs, captured together by the synchroniser
  typedef struct packed {
    logic tx_clk;
    logic tx_enb_n;
    logic tx_soc;
    logic tx_par;
    logic [ADDR_W-1:0] tx_addr;
    logic [WORD_W-1:0] tx_data;
    logic rx_clk;
    logic rx_enb_n;
    logic [ADDR_W-1:0] rx_addr;
  } upc_link_in_s;

  // Even parity of the active lanes; the caller inverts for odd
  function automatic logic upc_xor_lanes(input logic [WORD_W-1:0] d, input logic wide);
    logic r;
    r = wide ? ^d : ^d[BYTE_W-1:0];
    return r;
  endfunction

endpackage

// >>> logic/upc_fifo.sv
`timescale 1ns/10ps
module upc_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } upc_fifo_s;

  upc_fifo_s fifo_reg;
  upc_fifo_s fifo_next;
  logic push;
  logic pop;

  // Output stage is a register; the array counts only entries behind it
  assign in_ready = (fifo_reg.count != CNT_FULL);
  assign push = in_valid && in_ready;
  assign pop = (fifo_reg.count != '0) && (!fifo_reg.out_valid || out_ready);
  assign out_valid = fifo_reg.out_valid;
  assign out_data = fifo_reg.out_data;

  // Pointer, count and output stage update
  always_comb
  begin
    fifo_next = fifo_reg;
    if (push)
    begin
      fifo_next.mem[fifo_reg.wr_ptr] = in_data;
      fifo_next.wr_ptr = (fifo_reg.wr_ptr == PTR_LAST) ? '0 : fifo_reg.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      fifo_next.out_data = fifo_reg.mem[fifo_reg.rd_ptr];
      fifo_next.out_valid = 1'b1;
      fifo_next.rd_ptr = (fifo_reg.rd_ptr == PTR_LAST) ? '0 : fifo_reg.rd_ptr + 1'b1;
    end
    else if (out_ready)
    begin
      fifo_next.out_valid = 1'b0;
    end
    if (push && !pop)
    begin
      fifo_next.count = fifo_reg.count + 1'b1;
    end
    else if (pop && !push)
    begin
      fifo_next.count = fifo_reg.count - 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fifo_reg <= '0;
    end
    else
    begin
      fifo_reg <= fifo_next;
    end
  end

endmodule

// >>> logic/upc_phy_port.sv
// Contract
// - Drop data between cells until start word
// - Check transmit parity at transmit clock edge
// - After full cell, wait for start and enable
// - Capture transmit data on transmit clock rise
// - Link clock within 52 or 33 MHz
// - Drive cell space flag, tri-stateable, active high
// - Output receive words 16 or 8 bits
// - Drive receive bus only when enabled, selected
// - Generate receive parity, odd or even
// - Mark first receive word with start flag
// - Change receive outputs after receive clock rise
// - Words sampled at end of next cycle
// - Enable drivers only after enabled cycle
// - Drive cell ready flag, tri-stateable, active high
`timescale 1ns/10ps
module upc_phy_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Configuration
  input wire logic bus_16bit,
  input wire logic parity_odd,
  input wire logic multi_phy,
  input wire logic [upc_pkg::ADDR_W-1:0] phy_addr,
  // Transmit link from the ATM layer
  input wire logic atm_to_phy_clock,
  input wire logic [upc_pkg::WORD_W-1:0] atm_to_phy_cell_word,
  input wire logic atm_to_phy_parity,
  input wire logic atm_to_phy_cell_start,
  input wire logic atm_to_phy_enable_n,
  input wire logic [upc_pkg::ADDR_W-1:0] atm_to_phy_port_select,
  output logic atm_to_phy_cell_space,
  output logic atm_to_phy_cell_space_oe_n,
  // Receive link toward the ATM layer
  input wire logic phy_to_atm_clock,
  input wire logic phy_to_atm_enable_n,
  input wire logic [upc_pkg::ADDR_W-1:0] phy_to_atm_port_select,
  output logic [upc_pkg::WORD_W-1:0] phy_to_atm_cell_word,
  output logic phy_to_atm_parity,
  output logic phy_to_atm_cell_start,
  output logic phy_to_atm_bus_oe_n,
  output logic phy_to_atm_cell_ready,
  output logic phy_to_atm_cell_ready_oe_n,
  // Received cells toward the core
  output logic tx_cell_valid,
  input wire logic tx_cell_ready,
  output logic [upc_pkg::WORD_W-1:0] tx_cell_data,
  output logic tx_cell_first,
  output logic tx_cell_parity_error,
  // Cells from the core to send out
  input wire logic rx_cell_valid,
  output logic rx_cell_ready,
  input wire logic [upc_pkg::WORD_W-1:0] rx_cell_data,
  // Status pulses
  output logic tx_overflow,
  output logic tx_rate_error,
  output logic rx_rate_error
);

  import upc_pkg::*;

  typedef struct packed {
    upc_link_in_s s1;
    upc_link_in_s s2;
    upc_link_in_s s3;
    upc_tx_state_e tx_state;
    logic [5:0] tx_idx;
    logic tx_sel;
    logic q_valid;
    logic [TXQ_W-1:0] q_data;
    logic overflow;
    logic space;
    logic space_oe_n;
    logic [RATE_CNT_W-1:0] tx_rate_cnt;
    logic tx_rate_err;
    logic rx_sel;
    logic [5:0] rx_idx;
    logic stage_valid;
    logic [WORD_W-1:0] stage_data;
    logic in_ready;
    logic [WORD_W-1:0] rx_word;
    logic rx_par;
    logic rx_soc;
    logic rx_oe_n;
    logic rdy;
    logic rdy_oe_n;
    logic [RATE_CNT_W-1:0] rx_rate_cnt;
    logic rx_rate_err;
  } upc_state_s;

  upc_state_s state_reg;
  upc_state_s state_next;
  upc_link_in_s pins;
  logic q_ready;
  logic tx_edge;
  logic rx_edge;
  logic tx_take;
  logic rx_drive;
  logic tx_match;
  logic rx_match;
  logic [5:0] cell_last;
  logic [RATE_CNT_W-1:0] min_period;
  logic [WORD_W-1:0] tx_word;
  logic tx_perr;
  logic [WORD_W-1:0] rx_lanes;

  // All link pins travel through one synchroniser together
  assign pins.tx_clk = atm_to_phy_clock;
  assign pins.tx_enb_n = atm_to_phy_enable_n;
  assign pins.tx_soc = atm_to_phy_cell_start;
  assign pins.tx_par = atm_to_phy_parity;
  assign pins.tx_addr = atm_to_phy_port_select;
  assign pins.tx_data = atm_to_phy_cell_word;
  assign pins.rx_clk = phy_to_atm_clock;
  assign pins.rx_enb_n = phy_to_atm_enable_n;
  assign pins.rx_addr = phy_to_atm_port_select;

  // Edges seen on the second stage, data taken from the third; the third stage
  // is one core cycle older, so it still holds what stood before the link edge
  assign tx_edge = state_reg.s2.tx_clk && !state_reg.s3.tx_clk;
  assign rx_edge = state_reg.s2.rx_clk && !state_reg.s3.rx_clk;

  // Width dependent figures
  assign cell_last = bus_16bit ? CELL_LAST_16BIT : CELL_LAST_8BIT;
  assign min_period = bus_16bit ? RATE_CNT_W'(MIN_PERIOD_CYC_16BIT) : RATE_CNT_W'(MIN_PERIOD_CYC_8BIT);

  // Address decode; a single-PHY port answers every address
  assign tx_match = !multi_phy || (state_reg.s3.tx_addr == phy_addr);
  assign rx_match = !multi_phy || (state_reg.s3.rx_addr == phy_addr);

  // A transmit word counts only when enabled on a selected port
  assign tx_take = !state_reg.s3.tx_enb_n && state_reg.tx_sel;
  assign rx_drive = !state_reg.s3.rx_enb_n && state_reg.rx_sel;

  // In 8-bit mode the upper lanes are not looked at
  assign tx_word = bus_16bit ? state_reg.s3.tx_data : {UPPER_BYTE_ZERO, state_reg.s3.tx_data[BYTE_W-1:0]};
  assign tx_perr = upc_xor_lanes(tx_word, bus_16bit) ^ state_reg.s3.tx_par ^ parity_odd;
  assign rx_lanes = bus_16bit ? state_reg.stage_data : {UPPER_BYTE_ZERO, state_reg.stage_data[BYTE_W-1:0]};

  // Transmit queue; it cannot hold a whole cell, so the core must drain it
  upc_fifo #(
    .WIDTH(TXQ_W),
    .DEPTH(TXQ_DEPTH)
  ) u_txq (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(state_reg.q_valid),
    .in_ready(q_ready),
    .in_data(state_reg.q_data),
    .out_valid(tx_cell_valid),
    .out_ready(tx_cell_ready),
    .out_data({tx_cell_first, tx_cell_parity_error, tx_cell_data})
  );

  // Next state of the whole port
  always_comb
  begin
    state_next = state_reg;
    state_next.s1 = pins;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.q_valid = 1'b0;
    state_next.overflow = 1'b0;
    state_next.tx_rate_err = 1'b0;
    state_next.rx_rate_err = 1'b0;

    // A queued word the FIFO could not take is lost and reported
    if (state_reg.q_valid && !q_ready)
    begin
      state_next.overflow = 1'b1;
    end

    // Link period counters saturate so an idle clock never looks fast
    if (state_reg.tx_rate_cnt != RATE_CNT_MAX)
    begin
      state_next.tx_rate_cnt = state_reg.tx_rate_cnt + 1'b1;
    end
    if (state_reg.rx_rate_cnt != RATE_CNT_MAX)
    begin
      state_next.rx_rate_cnt = state_reg.rx_rate_cnt + 1'b1;
    end

    // Transmit direction, one step per link clock rise
    if (tx_edge)
    begin
      state_next.tx_rate_cnt = '0;
      if (state_reg.tx_rate_cnt < min_period)
      begin
        state_next.tx_rate_err = 1'b1;
      end
      // Selection is latched only while the enable is idle
      if (state_reg.s3.tx_enb_n)
      begin
        state_next.tx_sel = tx_match;
      end
      state_next.space = q_ready;
      state_next.space_oe_n = !tx_match;
      unique case (state_reg.tx_state)
        UPC_TX_IDLE:
        begin
          // Anything but an enabled start word is dropped here
          if (tx_take && state_reg.s3.tx_soc)
          begin
            state_next.q_valid = 1'b1;
            state_next.q_data = {1'b1, tx_perr, tx_word};
            state_next.tx_idx = CELL_IDX_SECOND;
            state_next.tx_state = UPC_TX_CELL;
          end
        end
        UPC_TX_CELL:
        begin
          if (tx_take)
          begin
            state_next.q_valid = 1'b1;
            state_next.q_data = {state_reg.s3.tx_soc, tx_perr, tx_word};
            // A start word inside a cell begins the cell again
            if (state_reg.s3.tx_soc)
            begin
              state_next.tx_idx = CELL_IDX_SECOND;
            end
            else if (state_reg.tx_idx == cell_last)
            begin
              state_next.tx_idx = CELL_IDX_FIRST;
              state_next.tx_state = UPC_TX_IDLE;
            end
            else
            begin
              state_next.tx_idx = state_reg.tx_idx + 1'b1;
            end
          end
        end
      endcase
    end

    // One-word staging register between the core and the receive link
    if (rx_cell_valid && state_reg.in_ready)
    begin
      state_next.stage_valid = 1'b1;
      state_next.stage_data = rx_cell_data;
    end

    // Receive direction; outputs move only just after a link clock rise
    if (rx_edge)
    begin
      state_next.rx_rate_cnt = '0;
      if (state_reg.rx_rate_cnt < min_period)
      begin
        state_next.rx_rate_err = 1'b1;
      end
      // Level 2 (multi-PHY) relies on the enable going idle between transfers
      if (state_reg.s3.rx_enb_n)
      begin
        state_next.rx_sel = rx_match;
      end
      state_next.rdy = state_reg.stage_valid;
      state_next.rdy_oe_n = !rx_match;
      // Drivers open in the cycle after an enabled, selected edge
      state_next.rx_oe_n = !rx_drive;
      if (rx_drive && state_reg.stage_valid)
      begin
        // Word stands until the next rise, where the ATM layer samples it
        state_next.rx_word = rx_lanes;
        state_next.rx_par = upc_xor_lanes(rx_lanes, bus_16bit) ^ parity_odd;
        state_next.rx_soc = (state_reg.rx_idx == CELL_IDX_FIRST);
        state_next.stage_valid = 1'b0;
        state_next.rx_idx = (state_reg.rx_idx == cell_last) ? CELL_IDX_FIRST : state_reg.rx_idx + 1'b1;
      end
      else if (rx_drive)
      begin
        // Core fell behind: the last word repeats without a start mark
        state_next.rx_soc = 1'b0;
      end
    end

    // Ready is registered from the next staging value, so it changes with the staging register in the same cycle
    state_next.in_ready = !state_next.stage_valid;
  end

  // State register; drivers come out of reset released
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
      state_reg.tx_state <= UPC_TX_IDLE;
      state_reg.tx_rate_cnt <= RATE_CNT_MAX;
      state_reg.rx_rate_cnt <= RATE_CNT_MAX;
      state_reg.space_oe_n <= 1'b1;
      state_reg.rx_oe_n <= 1'b1;
      state_reg.rdy_oe_n <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign atm_to_phy_cell_space = state_reg.space;
  assign atm_to_phy_cell_space_oe_n = state_reg.space_oe_n;
  assign phy_to_atm_cell_word = state_reg.rx_word;
  assign phy_to_atm_parity = state_reg.rx_par;
  assign phy_to_atm_cell_start = state_reg.rx_soc;
  assign phy_to_atm_bus_oe_n = state_reg.rx_oe_n;
  assign phy_to_atm_cell_ready = state_reg.rdy;
  assign phy_to_atm_cell_ready_oe_n = state_reg.rdy_oe_n;
  assign rx_cell_ready = state_reg.in_ready;
  assign tx_overflow = state_reg.overflow;
  assign tx_rate_error = state_reg.tx_rate_err;
  assign rx_rate_error = state_reg.rx_rate_err;

endmodule

// >>> test/upc_phy_port_assertions.sv
`timescale 1ns/10ps
module upc_phy_port_assertions (
  // Clock, reset and setup
  input wire logic core_clk,
  input wire logic rst,
  input wire logic parity_odd,
  input wire logic multi_phy,
  input wire logic [upc_pkg::ADDR_W-1:0] phy_addr,
  // Receive link
  input wire logic phy_to_atm_clock,
  input wire logic phy_to_atm_enable_n,
  input wire logic [upc_pkg::ADDR_W-1:0] phy_to_atm_port_select,
  input wire logic [upc_pkg::WORD_W-1:0] phy_to_atm_cell_word,
  input wire logic phy_to_atm_parity,
  input wire logic phy_to_atm_cell_start,
  input wire logic phy_to_atm_bus_oe_n,
  input wire logic phy_to_atm_cell_ready_oe_n,
  // Transmit link
  input wire logic [upc_pkg::ADDR_W-1:0] atm_to_phy_port_select,
  input wire logic atm_to_phy_cell_space,
  input wire logic atm_to_phy_cell_space_oe_n,
  input wire logic tx_overflow
);
  import upc_pkg::*;
  typedef struct packed {
    logic clk_prev;
    logic [2:0] since;
  } upc_chk_s;
  upc_chk_s chk_reg, chk_next;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Core cycles since the receive link clock rose, saturating so it never wraps
  always_comb
  begin
    chk_next = chk_reg;
    chk_next.clk_prev = phy_to_atm_clock;
    if (phy_to_atm_clock && !chk_reg.clk_prev)
      chk_next.since = 3'h0;
    else if (chk_reg.since != 3'h7)
      chk_next.since = chk_reg.since + 3'h1;
  end
  // Helper state register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      chk_reg <= '{clk_prev: 1'h0, since: 3'h7};
    else
      chk_reg <= chk_next;
  end
  // Six cycles back lies inside the link period before the edge that acted
  property p_oe_on;
    $fell(phy_to_atm_bus_oe_n) |-> !$past(phy_to_atm_enable_n, 6);
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus driven without enable");
  property p_oe_off;
    $rose(phy_to_atm_bus_oe_n) |-> $past(phy_to_atm_enable_n, 6);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus released while enabled");
  property p_par;
    !phy_to_atm_bus_oe_n |-> phy_to_atm_parity == ((^phy_to_atm_cell_word) ^ parity_odd);
  endproperty
  a_par: assert property (p_par) else $error("receive parity wrong");
  property p_sop;
    $rose(phy_to_atm_cell_start) |-> !phy_to_atm_bus_oe_n;
  endproperty
  a_sop: assert property (p_sop) else $error("cell start while bus released");
  property p_chg;
    $changed(phy_to_atm_cell_word) |-> chk_reg.since < 3'h6;
  endproperty
  a_chg: assert property (p_chg) else $error("receive word changed away from clock rise");
  property p_space_on;
    $fell(atm_to_phy_cell_space_oe_n) |-> !multi_phy || $past(atm_to_phy_port_select, 5) == phy_addr;
  endproperty
  a_space_on: assert property (p_space_on) else $error("space flag driven unselected");
  property p_space_off;
    $rose(atm_to_phy_cell_space_oe_n) |-> multi_phy && $past(atm_to_phy_port_select, 5) != phy_addr;
  endproperty
  a_space_off: assert property (p_space_off) else $error("space flag released while selected");
  property p_ready_on;
    $fell(phy_to_atm_cell_ready_oe_n) |-> !multi_phy || $past(phy_to_atm_port_select, 5) == phy_addr;
  endproperty
  a_ready_on: assert property (p_ready_on) else $error("ready flag driven unselected");
  property p_ovf;
    tx_overflow |-> !atm_to_phy_cell_space;
  endproperty
  a_ovf: assert property (p_ovf) else $error("word dropped while space shown");
  c_ovf: cover property (tx_overflow);
  c_sop: cover property ($rose(phy_to_atm_cell_start));
  c_off: cover property ($rose(atm_to_phy_cell_space_oe_n));
endmodule

bind upc_phy_port upc_phy_port_assertions upc_phy_port_assertions_i (
  .core_clk, .rst, .parity_odd, .multi_phy, .phy_addr, .phy_to_atm_clock,
  .phy_to_atm_enable_n, .phy_to_atm_port_select, .phy_to_atm_cell_word, .phy_to_atm_parity,
  .phy_to_atm_cell_start, .phy_to_atm_bus_oe_n, .phy_to_atm_cell_ready_oe_n,
  .atm_to_phy_port_select, .atm_to_phy_cell_space, .atm_to_phy_cell_space_oe_n, .tx_overflow
);

// >>> test/upc_atm_model.sv
`timescale 1ns/10ps
module upc_atm_model (
  // Transmit link
  output logic tx_clk,
  output logic [upc_pkg::WORD_W-1:0] tx_d,
  output logic tx_par,
  output logic tx_sop,
  output logic tx_en_n,
  // Receive link
  output logic rx_clk,
  output logic rx_en_n,
  input wire logic [upc_pkg::WORD_W-1:0] rx_d,
  input wire logic rx_par,
  input wire logic rx_sop,
  input wire logic rx_oe_n
);
  import upc_pkg::*;
  // Clocks stand low between beats; nothing enabled
  initial
  begin
    tx_clk = 1'h0;
    rx_clk = 1'h0;
    tx_d = 16'h0000;
    tx_par = 1'h0;
    tx_sop = 1'h0;
    tx_en_n = 1'h1;
    rx_en_n = 1'h1;
  end
  // One 80 ns link period (under both limits); values set at the rise count at the next
  task automatic tx_beat(input logic [WORD_W-1:0] w, input logic sop, input logic en_n, input logic bad);
    begin
      #41;
      tx_clk = 1'h1;
      tx_en_n <= en_n;
      tx_sop <= sop & ~en_n;
      tx_d <= en_n ? ~tx_d : w;
      tx_par <= en_n ? ~tx_par : (~^w) ^ bad;
      #39;
      tx_clk = 1'h0;
    end
  endtask
  // Samples what an enable two rises back asked for
  task automatic rx_beat(input logic en_n, output logic [WORD_W+2:0] s);
    begin
      #41;
      rx_clk = 1'h1;
      s = {rx_oe_n, rx_sop, rx_par, rx_d};
      rx_en_n <= en_n;
      #39;
      rx_clk = 1'h0;
    end
  endtask
endmodule

// >>> test/upc_phy_port_tb.sv
`timescale 1ns/10ps
module upc_phy_port_tb;
  import upc_pkg::*;
  logic core_clk, rst, bus_16bit, parity_odd, multi_phy, ovf_seen, full_seen;
  logic [ADDR_W-1:0] phy_addr, atm_to_phy_port_select, phy_to_atm_port_select;
  logic atm_to_phy_clock, atm_to_phy_parity, atm_to_phy_cell_start, atm_to_phy_enable_n;
  logic [WORD_W-1:0] atm_to_phy_cell_word, phy_to_atm_cell_word, tx_cell_data, rx_cell_data;
  logic atm_to_phy_cell_space, atm_to_phy_cell_space_oe_n, phy_to_atm_clock, phy_to_atm_enable_n;
  logic phy_to_atm_parity, phy_to_atm_cell_start, phy_to_atm_bus_oe_n;
  logic phy_to_atm_cell_ready, phy_to_atm_cell_ready_oe_n, tx_overflow, tx_rate_error, rx_rate_error, rate_seen;
  logic tx_cell_valid, tx_cell_ready, tx_cell_first, tx_cell_parity_error, rx_cell_valid, rx_cell_ready;
  int num_errors = 0;
  int total_checks = 0;
  logic [17:0] got[$];
  logic [WORD_W-1:0] feed[$];
  logic [WORD_W+2:0] smp[$];

  upc_phy_port upc_phy_port_i (
    .core_clk, .rst, .bus_16bit, .parity_odd, .multi_phy, .phy_addr,
    .atm_to_phy_clock, .atm_to_phy_cell_word, .atm_to_phy_parity, .atm_to_phy_cell_start,
    .atm_to_phy_enable_n, .atm_to_phy_port_select, .atm_to_phy_cell_space, .atm_to_phy_cell_space_oe_n,
    .phy_to_atm_clock, .phy_to_atm_enable_n, .phy_to_atm_port_select, .phy_to_atm_cell_word,
    .phy_to_atm_parity, .phy_to_atm_cell_start, .phy_to_atm_bus_oe_n, .phy_to_atm_cell_ready,
    .phy_to_atm_cell_ready_oe_n, .tx_cell_valid, .tx_cell_ready, .tx_cell_data, .tx_cell_first,
    .tx_cell_parity_error, .rx_cell_valid, .rx_cell_ready, .rx_cell_data, .tx_overflow,
    .tx_rate_error, .rx_rate_error
  );
  upc_atm_model upc_atm_model_i (
    .tx_clk(atm_to_phy_clock), .tx_d(atm_to_phy_cell_word), .tx_par(atm_to_phy_parity),
    .tx_sop(atm_to_phy_cell_start), .tx_en_n(atm_to_phy_enable_n), .rx_clk(phy_to_atm_clock),
    .rx_en_n(phy_to_atm_enable_n), .rx_d(phy_to_atm_cell_word), .rx_par(phy_to_atm_parity),
    .rx_sop(phy_to_atm_cell_start), .rx_oe_n(phy_to_atm_bus_oe_n)
  );

  // 200 MHz core clock
  initial
  begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Collect the queue output and watch for a full queue
  always @(posedge core_clk)
  begin
    if (tx_cell_valid === 1'h1 && tx_cell_ready === 1'h1)
      got.push_back({tx_cell_first, tx_cell_parity_error, tx_cell_data});
    if (tx_overflow === 1'h1)
      ovf_seen = 1'h1;
    if (atm_to_phy_cell_space === 1'h0 && atm_to_phy_cell_space_oe_n === 1'h0)
      full_seen = 1'h1;
    if (tx_rate_error === 1'h1 || rx_rate_error === 1'h1)
      rate_seen = 1'h1;
  end
  // Core feeder; idles a cycle after each transfer since the stage takes at most one word per receive link clock rise
  always @(posedge core_clk)
  begin
    if (rx_cell_valid === 1'h1 && rx_cell_ready === 1'h1)
    begin
      void'(feed.pop_front());
      rx_cell_valid <= 1'h0;
    end
    else if (feed.size() > 0)
    begin
      rx_cell_valid <= 1'h1;
      rx_cell_data <= feed[0];
    end
  end

  task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] seen);
    begin
      total_checks++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task automatic wait_got(input int n);
    int i;
    begin
      for (i = 0; i < 400 && got.size() < n; i++)
        @(posedge core_clk);
      repeat (16) @(posedge core_clk);
    end
  endtask

  task automatic test_tx;
    int i;
    begin
      got.delete();
      upc_atm_model_i.tx_beat(16'h5a5a, 1'h0, 1'h0, 1'h0);
      for (i = 0; i < 27; i++)
        upc_atm_model_i.tx_beat(16'h1000 + 16'(i), i == 0, 1'h0, i == 5);
      upc_atm_model_i.tx_beat(16'h0f0f, 1'h0, 1'h0, 1'h0);
      upc_atm_model_i.tx_beat(16'h0000, 1'h0, 1'h1, 1'h0);
      wait_got(27);
      chk("tx count", 19'h1b, 19'(got.size()));
      for (i = 0; i < 27; i++)
        chk("tx word", {1'h0, i == 0, i == 5, 16'h1000 + 16'(i)}, {1'h0, got[i]});
      $display("test_tx finished");
    end
  endtask
  task automatic test_full;
    int i;
    begin
      @(posedge core_clk);
      tx_cell_ready <= 1'h0;
      got.delete();
      ovf_seen = 1'h0;
      full_seen = 1'h0;
      for (i = 0; i < 12; i++)
        upc_atm_model_i.tx_beat(16'h3000 + 16'(i), i == 0, 1'h0, 1'h0);
      upc_atm_model_i.tx_beat(16'h0000, 1'h0, 1'h1, 1'h0);
      @(posedge core_clk);
      tx_cell_ready <= 1'h1;
      wait_got(8);
      chk("overflow", 19'h1, {18'h0, ovf_seen});
      chk("space low", 19'h1, {18'h0, full_seen});
      chk("kept", 19'h1, {18'h0, got.size() >= 8 && got.size() <= 9});
      chk("first kept", {3'h2, 16'h3000}, {1'h0, got[0]});
      $display("test_full finished");
    end
  endtask
  task automatic test_rx;
    int i;
    logic [18:0] s;
    logic [15:0] w;
    begin
      for (i = 0; i < 27; i++)
        feed.push_back(16'h2000 + 16'(i));
      for (i = 0; i < 50 && rx_cell_ready !== 1'h0; i++)
        @(posedge core_clk);
      chk("bus idle", 19'h1, {18'h0, phy_to_atm_bus_oe_n});
      for (i = 0; i < 30; i++)
      begin
        upc_atm_model_i.rx_beat(i >= 27, s);
        smp.push_back(s);
        if (i == 0)
          chk("cell ready", 19'h2, {17'h0, phy_to_atm_cell_ready, phy_to_atm_cell_ready_oe_n});
      end
      for (i = 0; i < 27; i++)
      begin
        w = 16'h2000 + 16'(i);
        chk("rx word", {1'h0, i == 0, ~^w, w}, smp[i + 2]);
      end
      chk("rx release", 19'h1, {18'h0, smp[29][18]});
      chk("cell ready", 19'h0, {17'h0, phy_to_atm_cell_ready, phy_to_atm_cell_ready_oe_n});
      $display("test_rx finished");
    end
  endtask
  task automatic test_sel;
    logic [18:0] s;
    begin
      @(posedge core_clk);
      atm_to_phy_port_select <= 5'h04;
      phy_to_atm_port_select <= 5'h04;
      got.delete();
      upc_atm_model_i.tx_beat(16'h0000, 1'h0, 1'h1, 1'h0);
      upc_atm_model_i.rx_beat(1'h1, s);
      upc_atm_model_i.tx_beat(16'h4000, 1'h1, 1'h0, 1'h0);
      upc_atm_model_i.rx_beat(1'h0, s);
      upc_atm_model_i.tx_beat(16'h0000, 1'h0, 1'h1, 1'h0);
      upc_atm_model_i.rx_beat(1'h1, s);
      upc_atm_model_i.rx_beat(1'h1, s);
      repeat (8) @(posedge core_clk);
      chk("tx unselected", 19'h0, 19'(got.size()));
      chk("space oe", 19'h1, {18'h0, atm_to_phy_cell_space_oe_n});
      chk("ready oe", 19'h1, {18'h0, phy_to_atm_cell_ready_oe_n});
      chk("rx unselected", 19'h1, {18'h0, s[18]});
      $display("test_sel finished");
    end
  endtask

  task automatic test_byte;
    int i;
    begin
      @(posedge core_clk);
      bus_16bit <= 1'h0;
      parity_odd <= 1'h0;
      multi_phy <= 1'h0;
      got.delete();
      // Upper byte ff adds no parity, so flipping the odd bit gives even parity
      for (i = 0; i < 54; i++)
        upc_atm_model_i.tx_beat(16'hff00 + 16'(i), i == 0, 1'h0, 1'h1);
      upc_atm_model_i.tx_beat(16'h0000, 1'h0, 1'h1, 1'h0);
      wait_got(53);
      chk("byte count", 19'h35, 19'(got.size()));
      chk("byte word", {3'h2, 16'h0000}, {1'h0, got[0]});
      chk("rate error", 19'h0, {18'h0, rate_seen});
      $display("test_byte finished");
    end
  endtask

  task automatic give_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Tests need about 11 us; cut a hang well past that
  initial
  begin
    #60000;
    num_errors++;
    $display("watchdog expired");
    give_verdict();
  end
  initial
  begin
    rst = 1'h1;
    bus_16bit = 1'h1;
    parity_odd = 1'h1;
    multi_phy = 1'h1;
    phy_addr = 5'h03;
    atm_to_phy_port_select = 5'h03;
    phy_to_atm_port_select = 5'h03;
    tx_cell_ready = 1'h1;
    rx_cell_valid = 1'h0;
    rx_cell_data = 16'h0000;
    ovf_seen = 1'h0;
    full_seen = 1'h0;
    rate_seen = 1'h0;
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    repeat (3) @(posedge core_clk);
    test_tx();
    test_full();
    test_rx();
    test_sel();
    test_byte();
    give_verdict();
  end
endmodule
